// >>> rtl/pss_sequencer.sv
// start-up, reset and link timing sequencer of the phy
//
// Behaviour
// - While the platform lan reset is low the phy core reset is held asserted.
// - Reset complete is indicated at most ten milliseconds after reset release.
// - The crystal is stable at most five milliseconds after power ramp end.
// - Internal power-on reset fires within one microsecond of crystal stable.
// - The link clock output is stable within three microseconds of power-on reset.
// - The serial transmitter is valid within 200 ns of leaving electrical idle.
// - The serial receiver accepts data within 200 ns of leaving electrical idle.
// - Auto-negotiation starts 1.2 s to 1.3 s after cable connection.
`include "pss_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module pss_sequencer #(
   parameter int unsigned XTAL_CYC      = 32'(`PSS_XTAL_CYC),
   parameter int unsigned PHY_RESET_CYC = 32'(`PSS_PHY_RESET_CYC),
   parameter int unsigned AN_MIN_CYC    = 32'(`PSS_AN_MIN_CYC),
   parameter int unsigned AN_MAX_CYC    = 32'(`PSS_AN_MAX_CYC),
   parameter int unsigned CW            = 27
)(
   input  wire logic         i_clock,
   input  wire logic         i_reset_n,
   input  wire logic         i_link_clk,
   input  wire logic         i_power_good,
   input  wire logic         i_platform_lan_reset_n,
   input  wire logic         i_cable_connected,
   input  wire logic         i_elec_idle,
   output var  pss_pkg::pss_status_t o_status,
   output var  pss_pkg::pss_serdes_t o_serdes,
   output logic              o_link_clock_out_en,
   output logic              o_an_start,
   output logic              o_link_reset_seen
);
   localparam int unsigned POR_CYC  = 32'(`PSS_POR_CYC);
   localparam int unsigned LCLK_CYC = 32'(`PSS_LCLK_CYC);
   localparam int unsigned IDLE_CYC = 32'(`PSS_IDLE_EXIT_CYC);
   localparam logic [CW-1:0] ONE    = CW'(1);

   //==========================================================
   // pin synchronisers: three stages, change counts when 2 and 3 agree
   //==========================================================
   logic [2:0] pg_sync_reg, lan_sync_reg, cab_sync_reg, idle_sync_reg;
   logic       pg_reg, lan_reg, cab_reg, idle_reg;

   // stage one is read only by stage two
   always_ff @(posedge i_clock or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         pg_sync_reg   <= 3'h0;
         lan_sync_reg  <= 3'h0;
         cab_sync_reg  <= 3'h0;
         idle_sync_reg <= 3'h7;
      end
      else
      begin
         pg_sync_reg   <= {pg_sync_reg[1:0], i_power_good};
         lan_sync_reg  <= {lan_sync_reg[1:0], i_platform_lan_reset_n};
         cab_sync_reg  <= {cab_sync_reg[1:0], i_cable_connected};
         idle_sync_reg <= {idle_sync_reg[1:0], i_elec_idle};
      end
   end

   // filtered levels follow once stages two and three agree
   always_ff @(posedge i_clock or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         pg_reg   <= 1'b0;
         lan_reg  <= 1'b0;
         cab_reg  <= 1'b0;
         idle_reg <= 1'b1;
      end
      else
      begin
         if (pg_sync_reg[1] == pg_sync_reg[2])
            pg_reg <= pg_sync_reg[2];
         if (lan_sync_reg[1] == lan_sync_reg[2])
            lan_reg <= lan_sync_reg[2];
         if (cab_sync_reg[1] == cab_sync_reg[2])
            cab_reg <= cab_sync_reg[2];
         if (idle_sync_reg[1] == idle_sync_reg[2])
            idle_reg <= idle_sync_reg[2];
      end
   end

   //==========================================================
   // start-up state machine
   //==========================================================
   pss_pkg::pss_state_t state_reg;
   logic [CW-1:0]       cnt_reg;
   logic                last;

   assign last = (cnt_reg == ONE);

   // a platform reset or power loss drops back; off waits for power good
   always_ff @(posedge i_clock or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         state_reg <= pss_pkg::PSS_S_OFF;
         cnt_reg   <= '0;
      end
      else if (!pg_reg)
      begin
         state_reg <= pss_pkg::PSS_S_OFF;
         cnt_reg   <= '0;
      end
      else
      begin
         case (state_reg)
            pss_pkg::PSS_S_OFF:
            begin
               state_reg <= pss_pkg::PSS_S_XTAL;
               cnt_reg   <= CW'(XTAL_CYC);
            end
            pss_pkg::PSS_S_XTAL:
               if (last)
               begin
                  state_reg <= pss_pkg::PSS_S_POR;
                  cnt_reg   <= CW'(POR_CYC);
               end
               else
                  cnt_reg <= cnt_reg - ONE;
            pss_pkg::PSS_S_POR:
               if (last)
               begin
                  state_reg <= pss_pkg::PSS_S_LCLK;
                  cnt_reg   <= CW'(LCLK_CYC);
               end
               else
                  cnt_reg <= cnt_reg - ONE;
            pss_pkg::PSS_S_LCLK:
               if (last)
               begin
                  state_reg <= pss_pkg::PSS_S_RESET;
                  cnt_reg   <= CW'(PHY_RESET_CYC);
               end
               else
                  cnt_reg <= cnt_reg - ONE;
            pss_pkg::PSS_S_RESET:
               if (!lan_reg)
                  cnt_reg <= CW'(PHY_RESET_CYC);
               else if (last)
                  state_reg <= pss_pkg::PSS_S_READY;
               else
                  cnt_reg <= cnt_reg - ONE;
            pss_pkg::PSS_S_READY:
               if (!lan_reg)
               begin
                  state_reg <= pss_pkg::PSS_S_RESET;
                  cnt_reg   <= CW'(PHY_RESET_CYC);
               end
            default:
            begin
               state_reg <= pss_pkg::PSS_S_OFF;
               cnt_reg   <= '0;
            end
         endcase
      end
   end

   // status outputs straight from flip-flops
   always_ff @(posedge i_clock or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         o_status            <= '0;
         o_link_clock_out_en <= 1'b0;
      end
      else
      begin
         o_link_clock_out_en <= pg_reg && (state_reg >= pss_pkg::PSS_S_LCLK);
         o_status.link_clock_stable <= pg_reg && (state_reg >= pss_pkg::PSS_S_RESET);
         // core reset released only with platform reset high and clock stable
         o_status.phy_core_reset_n <= pg_reg && lan_reg && (state_reg >= pss_pkg::PSS_S_RESET);
         o_status.reset_done <= pg_reg && lan_reg && (state_reg == pss_pkg::PSS_S_READY);
      end
   end

   //==========================================================
   // serial link idle exit timing
   //==========================================================
   logic [7:0] idle_cnt_reg;

   // both directions come up together; worst case is the shared bound
   always_ff @(posedge i_clock or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         idle_cnt_reg <= 8'h00;
         o_serdes     <= '0;
      end
      else if (idle_reg || !o_status.link_clock_stable)
      begin
         idle_cnt_reg <= 8'(IDLE_CYC - 1);
         o_serdes     <= '0;
      end
      else if (idle_cnt_reg != 8'h00)
         idle_cnt_reg <= idle_cnt_reg - 8'h01;
      else
      begin
         o_serdes.tx_valid <= 1'b1;
         o_serdes.rx_ready <= 1'b1;
      end
   end

   //==========================================================
   // cable connect to auto-negotiation start
   //==========================================================
   logic [CW:0] an_cnt_reg;
   logic        an_armed_reg;

   // start lands at the midpoint of the window, safely inside both bounds
   always_ff @(posedge i_clock or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         an_cnt_reg   <= '0;
         an_armed_reg <= 1'b0;
         o_an_start   <= 1'b0;
      end
      else
      begin
         o_an_start <= 1'b0;
         if (!cab_reg || !o_status.reset_done)
         begin
            an_armed_reg <= 1'b0;
            an_cnt_reg   <= '0;
         end
         else if (!an_armed_reg)
         begin
            an_armed_reg <= 1'b1;
            an_cnt_reg   <= (CW+1)'((AN_MIN_CYC + AN_MAX_CYC) / 2 - 1);
         end
         else if (an_cnt_reg == '0)
         begin
            an_cnt_reg <= '1;                              // park: one start per connect
            o_an_start <= 1'b1;
         end
         else if (an_cnt_reg != '1)
            an_cnt_reg <= an_cnt_reg - (CW+1)'(1);
      end
   end

   //==========================================================
   // link reset sync pulse on the link clock domain
   //==========================================================
   logic [2:0] lrs_sync_reg;
   logic       lrs_toggle_reg;
   logic [2:0] lrs_back_reg;

   // link clock may stop; only a toggle crosses, so no edge is lost
   always_ff @(posedge i_link_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         lrs_sync_reg   <= 3'h0;
         lrs_toggle_reg <= 1'b0;
      end
      else
      begin
         lrs_sync_reg <= {lrs_sync_reg[1:0], o_status.reset_done};
         if (lrs_sync_reg[2] != lrs_sync_reg[1])
            lrs_toggle_reg <= ~lrs_toggle_reg;
      end
   end

   // toggle back into the main clock, flagged as a one-cycle pulse
   always_ff @(posedge i_clock or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         lrs_back_reg      <= 3'h0;
         o_link_reset_seen <= 1'b0;
      end
      else
      begin
         lrs_back_reg      <= {lrs_back_reg[1:0], lrs_toggle_reg};
         o_link_reset_seen <= lrs_back_reg[2] ^ lrs_back_reg[1];
      end
   end

   //==========================================================
   // checks
   //==========================================================
   property p_core_reset_held;
      @(posedge i_clock) disable iff (!i_reset_n)
      !lan_reg |=> !o_status.phy_core_reset_n;
   endproperty
   a_core_reset_held: assert property (p_core_reset_held) else $error("core reset released under lan reset");

   property p_done_needs_clock;
      @(posedge i_clock) disable iff (!i_reset_n)
      o_status.reset_done |-> o_status.link_clock_stable && o_status.phy_core_reset_n;
   endproperty
   a_done_needs_clock: assert property (p_done_needs_clock) else $error("reset done too early");

   sequence s_idle_exit;
      $fell(idle_reg) && o_status.link_clock_stable;
   endsequence
   property p_tx_valid;
      @(posedge i_clock) disable iff (!i_reset_n)
      s_idle_exit ##1 (!idle_reg && o_status.link_clock_stable)[*7] |-> ##1 o_serdes.tx_valid;
   endproperty
   a_tx_valid: assert property (p_tx_valid) else $error("tx not valid after idle exit");

   property p_rx_ready;
      @(posedge i_clock) disable iff (!i_reset_n)
      idle_reg |=> !o_serdes.rx_ready;
   endproperty
   a_rx_ready: assert property (p_rx_ready) else $error("rx ready during idle");

   property p_an_needs_cable;
      @(posedge i_clock) disable iff (!i_reset_n)
      o_an_start |-> $past(cab_reg) && $past(o_status.reset_done);
   endproperty
   a_an_needs_cable: assert property (p_an_needs_cable) else $error("negotiation without cable");

   property p_por_to_clock;
      @(posedge i_clock) disable iff (!i_reset_n)
      (state_reg == pss_pkg::PSS_S_POR) && pg_reg |-> ##[1:60] o_link_clock_out_en || !pg_reg;
   endproperty
   a_por_to_clock: assert property (p_por_to_clock) else $error("clock not started after por");

   property p_clock_stable;
      @(posedge i_clock) disable iff (!i_reset_n)
      $rose(o_link_clock_out_en) |-> ##[1:130] o_status.link_clock_stable || !pg_reg;
   endproperty
   a_clock_stable: assert property (p_clock_stable) else $error("link clock not stable in time");

   property p_done_pulse_off;
      @(posedge i_clock) disable iff (!i_reset_n)
      !pg_reg |=> !o_status.reset_done && !o_link_clock_out_en;
   endproperty
   a_done_pulse_off: assert property (p_done_pulse_off) else $error("outputs alive without power");

endmodule
`default_nettype wire

// >>> shared/pss_consts.svh
// timing constants for the phy start-up and reset sequencer
`ifndef PSS_CONSTS_SVH
`define PSS_CONSTS_SVH
// clock period in picoseconds (40 mhz)
`define PSS_CLK_PS            25000
// time figures in their own unit
`define PSS_PHY_RESET_MAX_MS  10
`define PSS_XTAL_MAX_MS       5
`define PSS_POR_MAX_US        1
`define PSS_LCLK_MAX_US       3
`define PSS_IDLE_EXIT_MAX_NS  200
`define PSS_AN_MIN_MS         1200
`define PSS_AN_MAX_MS         1300
// derived cycle counts; maxima round down, minima round up
`define PSS_PHY_RESET_CYC     ((`PSS_PHY_RESET_MAX_MS * 64'd1000000000) / `PSS_CLK_PS)
`define PSS_XTAL_CYC          ((`PSS_XTAL_MAX_MS * 64'd1000000000) / `PSS_CLK_PS)
`define PSS_POR_CYC           ((`PSS_POR_MAX_US * 64'd1000000) / `PSS_CLK_PS)
`define PSS_LCLK_CYC          ((`PSS_LCLK_MAX_US * 64'd1000000) / `PSS_CLK_PS)
`define PSS_IDLE_EXIT_CYC     ((`PSS_IDLE_EXIT_MAX_NS * 64'd1000) / `PSS_CLK_PS)
`define PSS_AN_MIN_CYC        ((`PSS_AN_MIN_MS * 64'd1000000000 + `PSS_CLK_PS - 1) / `PSS_CLK_PS)
`define PSS_AN_MAX_CYC        ((`PSS_AN_MAX_MS * 64'd1000000000) / `PSS_CLK_PS)
`endif

// >>> shared/pss_pkg.sv
// types for the phy start-up and reset sequencer
package pss_pkg;
   typedef enum logic [2:0] {
      PSS_S_OFF,
      PSS_S_XTAL,
      PSS_S_POR,
      PSS_S_LCLK,
      PSS_S_RESET,
      PSS_S_READY
   } pss_state_t;

   // status bundle toward the mac side
   typedef struct packed {
      logic link_clock_stable;
      logic phy_core_reset_n;
      logic reset_done;
   } pss_status_t;

   // serial link idle exit state
   typedef struct packed {
      logic tx_valid;
      logic rx_ready;
   } pss_serdes_t;
endpackage

// >>> verification/pss_mac_model.sv
// behavioural model of the mac side: power good, platform lan reset, link clock
`timescale 1ns/1ps
`default_nettype none

module pss_mac_model #(
   parameter int HOLD_CYC = 10,
   parameter int CFG_CYC  = 30,
   parameter int SYNC_LEN = 4
)(
   input  wire logic i_clock,
   input  wire logic i_power_on,
   input  wire logic i_lan_hold,
   input  wire logic i_reset_done,
   input  wire logic i_cable,
   output var  logic o_power_good,
   output var  logic o_platform_lan_reset_n,
   output var  logic o_link_clk,
   output var  logic o_cfg_busy,
   output var  logic o_link_reset_sync_pulse
);
   int   hold_cnt;
   int   cfg_cnt;
   int   sync_cnt;
   logic pon;
   logic hold;
   logic done_s;
   logic done_q;
   logic cab_s;
   logic cab_q;
   logic sync_done_q;

   // ==========================================
   // power and lan reset
   initial
   begin
      o_power_good = 1'b0;
      o_platform_lan_reset_n = 1'b0;
      o_cfg_busy = 1'b0;
      o_link_reset_sync_pulse = 1'b0;
      hold_cnt = HOLD_CYC;
      cfg_cnt = 0;
      sync_cnt = 0;
      done_q = 1'b0;
      cab_q = 1'b0;
      sync_done_q = 1'b0;
   end

   // inputs taken at the edge, outputs moved just after it, so the bench drive never races
   always @(posedge i_clock)
   begin
      pon = i_power_on;
      hold = i_lan_hold;
      done_s = i_reset_done;
      cab_s = i_cable;
      #2;
      o_power_good <= pon;
      // reset held through the ramp plus a margin, so nothing leaves reset on a sagging rail
      if (!pon || hold)
         hold_cnt = HOLD_CYC;
      else if (hold_cnt > 0)
         hold_cnt = hold_cnt - 1;
      o_platform_lan_reset_n <= (hold_cnt == 0) && pon;
      // configuration waits for reset complete and ends well inside its deadline
      if (!done_s)
         cfg_cnt = 0;
      else if (!done_q || (cab_s && !cab_q))
         cfg_cnt = CFG_CYC;
      else if (cfg_cnt > 0)
         cfg_cnt = cfg_cnt - 1;
      o_cfg_busy <= (cfg_cnt > 0);
      done_q = done_s;
      cab_q = cab_s;
   end

   // sync pulse issued on each reset completion, held for its full minimum width
   always @(posedge o_link_clk)
   begin
      if (sync_cnt > 0)
         sync_cnt = sync_cnt - 1;
      else if (i_reset_done && !sync_done_q)
         sync_cnt = SYNC_LEN;
      sync_done_q = i_reset_done;
      o_link_reset_sync_pulse <= (sync_cnt > 0);
   end

   // ==========================================
   // link clock, 160 ns, odd phase; stands still while unpowered
   initial
   begin
      o_link_clk = 1'b0;
      #37;
      forever
      begin
         #80;
         o_link_clk = o_power_good ? ~o_link_clk : 1'b0;
      end
   end
endmodule

`default_nettype wire

// >>> verification/tb_phy_startup_reset_sequencer.sv
// self-checking bench for the phy start-up and reset sequencer
`timescale 1ns/1ps
`default_nettype none

module tb_phy_startup_reset_sequencer;
   localparam int XTAL   = 20;
   localparam int PHYR   = 50;
   localparam int AN_MIN = 100;
   localparam int AN_MAX = 140;
   localparam int CFG    = 30;
   localparam int SYNC   = 4;

   logic                 clock;
   logic                 reset_n;
   logic                 power_on;
   logic                 lan_hold;
   logic                 cable;
   logic                 elec_idle;
   wire logic            power_good;
   wire logic            lan_reset_n;
   wire logic            link_clk;
   wire logic            cfg_busy;
   wire logic            sync_pulse;
   int                   sync_hi;
   pss_pkg::pss_status_t status;
   pss_pkg::pss_serdes_t serdes;
   logic                 clk_en;
   logic                 an_start;
   logic                 link_seen;
   int                   n_fail;
   int                   checks_done;
   int                   cycles;
   int                   seen_cnt;
   int                   an_cnt;

   // ==========================================
   // instances
   pss_mac_model #(
      .CFG_CYC  (CFG),
      .SYNC_LEN (SYNC)
   ) mac (
      .i_clock                 (clock),
      .i_power_on              (power_on),
      .i_lan_hold              (lan_hold),
      .i_reset_done            (status.reset_done),
      .i_cable                 (cable),
      .o_power_good            (power_good),
      .o_platform_lan_reset_n  (lan_reset_n),
      .o_link_clk              (link_clk),
      .o_cfg_busy              (cfg_busy),
      .o_link_reset_sync_pulse (sync_pulse)
   );

   pss_sequencer #(
      .XTAL_CYC      (XTAL),
      .PHY_RESET_CYC (PHYR),
      .AN_MIN_CYC    (AN_MIN),
      .AN_MAX_CYC    (AN_MAX)
   ) dut (
      .i_clock                (clock),
      .i_reset_n              (reset_n),
      .i_link_clk             (link_clk),
      .i_power_good           (power_good),
      .i_platform_lan_reset_n (lan_reset_n),
      .i_cable_connected      (cable),
      .i_elec_idle            (elec_idle),
      .o_status               (status),
      .o_serdes               (serdes),
      .o_link_clock_out_en    (clk_en),
      .o_an_start             (an_start),
      .o_link_reset_seen      (link_seen)
   );

   // ==========================================
   // clock, pulse counters, hang guard
   initial
   begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   // pulses are one cycle wide, so they are counted every edge
   always @(posedge clock)
   begin
      cycles++;
      if (link_seen === 1'b1) seen_cnt++;
      if (an_start === 1'b1) an_cnt++;
      if (cycles == 4000)
      begin
         n_fail++;
         $display("timeout at %0t", $time);
         summarize();
      end
   end

   // sync pulse width counted in link clock cycles
   always @(posedge link_clk)
      if (sync_pulse === 1'b1) sync_hi++;

   // ==========================================
   // helpers
   function automatic logic pick(input int s);
      case (s)
         0: return clk_en;
         1: return status.link_clock_stable;
         2: return status.reset_done;
         3: return serdes.tx_valid;
         4: return status.phy_core_reset_n;
         6: return cfg_busy;
         default: return an_start;
      endcase
   endfunction

   task automatic tick(input int k);
      repeat (k) @(posedge clock);
      #2;
   endtask

   // n runs past lim when the level never shows
   task automatic wait_lvl(input int s, input logic v, input int lim, output int n);
      n = 0;
      while (n <= lim && pick(s) !== v)
      begin
         tick(1);
         n++;
      end
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      if (got !== exp) n_fail++;
   endtask

   task automatic chk_le(input logic [31:0] got, input logic [31:0] lim);
      checks_done++;
      if (got > lim)
      begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h limit=%h", $time, got, lim);
      end
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // ==========================================
   // scenarios
   task automatic t_powerup();
      int n;
      power_on = 1'b1;
      wait_lvl(0, 1'b1, XTAL + 48, n);
      chk_le(n, XTAL + 48);
      wait_lvl(1, 1'b1, 122, n);
      chk_le(n, 122);
      chk(status.reset_done, 1'b0);
      chk(cfg_busy, 1'b0);
      wait_lvl(2, 1'b1, PHYR + 6, n);
      chk_le(n, PHYR + 6);
      chk(status.phy_core_reset_n, 1'b1);
      tick(2);
      chk(cfg_busy, 1'b1);
      wait_lvl(6, 1'b0, CFG + 2, n);
      chk_le(n, CFG + 2);
      $display("powerup test done");
   endtask

   // lan reset dropped in mid-run, then released; the link clock echoes both edges
   task automatic t_lan();
      int n;
      int s0;
      int y0;
      // let the echo of the start-up completion pass first
      tick(60);
      s0 = seen_cnt;
      y0 = sync_hi;
      lan_hold = 1'b1;
      wait_lvl(4, 1'b0, 8, n);
      chk_le(n, 8);
      tick(1);
      chk(status.reset_done, 1'b0);
      tick(20);
      chk(status.phy_core_reset_n, 1'b0);
      lan_hold = 1'b0;
      wait_lvl(2, 1'b1, PHYR + 20, n);
      chk_le(n, PHYR + 20);
      tick(60);
      chk(seen_cnt - s0, 2);
      chk(sync_hi - y0, SYNC);
      $display("lan reset test done");
   endtask

   // power lost in mid-run: everything drops, then the whole chain runs again
   task automatic t_power();
      int n;
      power_on = 1'b0;
      wait_lvl(0, 1'b0, 8, n);
      chk_le(n, 8);
      chk({status, serdes}, 32'h0);
      power_on = 1'b1;
      wait_lvl(2, 1'b1, XTAL + 48 + 122 + PHYR + 8, n);
      chk_le(n, XTAL + 48 + 122 + PHYR + 8);
      $display("power loss test done");
   endtask

   task automatic t_idle();
      int n;
      elec_idle = 1'b0;
      wait_lvl(3, 1'b1, 14, n);
      chk_le(n, 14);
      chk(serdes.rx_ready, 1'b1);
      elec_idle = 1'b1;
      wait_lvl(3, 1'b0, 6, n);
      chk_le(n, 6);
      chk(serdes.rx_ready, 1'b0);
      $display("idle exit test done");
   endtask

   // one start per connect; a drop re-arms it
   task automatic t_autoneg();
      int n;
      int a0;
      a0 = an_cnt;
      cable = 1'b1;
      wait_lvl(5, 1'b1, AN_MAX + 8, n);
      chk_le(n, AN_MAX + 8);
      chk_le(AN_MIN, n);
      tick(200);
      chk(an_cnt - a0, 1);
      cable = 1'b0;
      tick(10);
      cable = 1'b1;
      wait_lvl(5, 1'b1, AN_MAX + 8, n);
      chk_le(n, AN_MAX + 8);
      chk_le(AN_MIN, n);
      $display("autoneg test done");
   endtask

   // ==========================================
   // main sequence
   initial
   begin
      n_fail = 0;
      checks_done = 0;
      cycles = 0;
      seen_cnt = 0;
      an_cnt = 0;
      sync_hi = 0;
      reset_n = 1'b0;
      power_on = 1'b0;
      lan_hold = 1'b0;
      cable = 1'b0;
      elec_idle = 1'b1;
      tick(20);
      chk({status, serdes, clk_en, an_start, link_seen}, 32'h0);
      reset_n = 1'b1;
      tick(2);
      t_powerup();
      t_lan();
      t_idle();
      t_power();
      t_autoneg();
      summarize();
   end
endmodule

`default_nettype wire
